// File: logic/i2c_master_ctrl.v
// Register file, byte engine and interrupt line of the two-wire bus master unit.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "i2c_master_defines.vh"
module i2c_master_ctrl (
	input wire clk_i,
	input wire rst_i,
	input wire [15:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	input wire bit_clk_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	input wire scl_i,
	output wire scl_o,
	output wire scl_oe_o,
	output wire irq_o
);
	// -------------------------------------------------------------
	// States and storage
	// -------------------------------------------------------------
	localparam [6:0] ST_IDLE = 7'b0000001;
	localparam [6:0] ST_START = 7'b0000010;
	localparam [6:0] ST_HOLD = 7'b0000100;
	localparam [6:0] ST_TX = 7'b0001000;
	localparam [6:0] ST_RX = 7'b0010000;
	localparam [6:0] ST_STOP = 7'b0100000;
	localparam [6:0] ST_RSTART = 7'b1000000;

	reg [6:0] state;
	reg [1:0] phase;
	reg [3:0] bit_cnt;
	reg [7:0] shifter;
	reg [7:0] byte_data_field;
	reg module_enable_bit;
	reg noise_filter_on;
	reg stop_request;
	reg start_request;
	reg transmit_go;
	reg receive_go;
	reg ack_bit;
	reg receive_ready_flag;
	reg transmit_busy_flag;
	reg receive_busy_flag;
	reg tx_empty_pending;
	reg tx_empty_irq_enable;
	reg rx_full_irq_enable;
	reg bus_busy;
	reg scl_drive_low;
	reg sda_drive_low;
	reg tick_prev;
	wire tick;
	wire sda_clean;
	wire scl_clean;
	wire wr_en;
	wire wr_ctl;
	wire wr_dat;
	wire wr_ictl;
	wire rd_dat;
	wire load_tx;
	wire load_rx;
	wire rx_done;
	wire stop_ok;

	// -------------------------------------------------------------
	// Input filters and bit clock edge
	// -------------------------------------------------------------
	// Both bus inputs share one filter switch.
	line_filter sda_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.on_i(noise_filter_on),
		.raw_i(sda_i),
		.clean_o(sda_clean)
	);
	line_filter scl_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.on_i(noise_filter_on),
		.raw_i(scl_i),
		.clean_o(scl_clean)
	);

	// Quarter-bit phases advance on rising edges of the timer clock. A released clock line
	// that still reads low means a slave is stretching it, so the high phase waits for it.
	assign tick = bit_clk_i & ~tick_prev & module_enable_bit &
		(scl_clean | scl_drive_low | (phase != `PHASE_SAMPLE));

	// -------------------------------------------------------------
	// Register bus decode
	// -------------------------------------------------------------
	assign wr_en = wr_i && (addr_i == `ADDR_MASTER_ENABLE);
	assign wr_ctl = wr_i && (addr_i == `ADDR_MASTER_CONTROL);
	assign wr_dat = wr_i && (addr_i == `ADDR_MASTER_DATA);
	assign wr_ictl = wr_i && (addr_i == `ADDR_IRQ_CONTROL);
	assign rd_dat = rd_i && (addr_i == `ADDR_MASTER_DATA);

	// Engine events that load a byte to send, start a receive, finish a received byte, or allow a stop.
	assign load_tx = tick && (phase == `PHASE_LAST) && transmit_go && bus_busy &&
		((state == ST_HOLD) || ((state == ST_TX || state == ST_RX) && bit_cnt == `LAST_BIT));
	assign load_rx = tick && (phase == `PHASE_LAST) && !transmit_go && receive_go &&
		bus_busy && ((state == ST_HOLD) ||
		((state == ST_TX || state == ST_RX) && bit_cnt == `LAST_BIT));
	assign rx_done = tick && (state == ST_RX) && (phase == `PHASE_LAST) &&
		(bit_cnt == `LAST_BIT);
	assign stop_ok = stop_request && !transmit_go && !receive_go && !start_request;

	// Clock line: the engine holds it low in phases 0 and 1 of each bit.
	assign scl_o = 1'b0;
	assign scl_oe_o = scl_drive_low;
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_drive_low;

	// Shared request line, each cause gated by its own enable.
	assign irq_o = (tx_empty_pending & tx_empty_irq_enable) |
		(receive_ready_flag & rx_full_irq_enable);

	// -------------------------------------------------------------
	// Read data, one cycle after the strobe
	// -------------------------------------------------------------
	// Unused bits and unmapped addresses answer zero.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= `ZERO16;
		end else begin
			rdata_o <= `ZERO16;
			if (rd_i) begin
				case (addr_i)
				`ADDR_MASTER_ENABLE: begin
					rdata_o[`BIT_ENABLE] <= module_enable_bit;
				end
				`ADDR_MASTER_CONTROL: begin
					rdata_o[`BIT_RX_BUSY] <= receive_busy_flag;
					rdata_o[`BIT_TX_BUSY] <= transmit_busy_flag;
					rdata_o[`BIT_FILTER] <= noise_filter_on;
					rdata_o[`BIT_STOP] <= stop_request;
					rdata_o[`BIT_START] <= start_request;
				end
				`ADDR_MASTER_DATA: begin
					rdata_o[`BIT_RX_READY] <= receive_ready_flag;
					rdata_o[`BIT_RX_GO] <= receive_go;
					rdata_o[`BIT_TX_GO] <= transmit_go;
					rdata_o[`BIT_ACK] <= ack_bit;
					rdata_o[7:0] <= byte_data_field;
				end
				`ADDR_IRQ_CONTROL: begin
					rdata_o[`BIT_RX_IRQ_EN] <= rx_full_irq_enable;
					rdata_o[`BIT_TX_IRQ_EN] <= tx_empty_irq_enable;
				end
				default: begin
					rdata_o <= `ZERO16;
				end
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Software-visible control bits
	// -------------------------------------------------------------
	// Hardware set events win over software clears in the same cycle.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			module_enable_bit <= 1'b0;
			noise_filter_on <= 1'b0;
			tx_empty_irq_enable <= 1'b0;
			rx_full_irq_enable <= 1'b0;
			byte_data_field <= `ZERO8;
			transmit_go <= 1'b0;
			receive_go <= 1'b0;
			ack_bit <= 1'b0;
			receive_ready_flag <= 1'b0;
			tx_empty_pending <= 1'b0;
		end else begin
			if (wr_en)
				module_enable_bit <= wdata_i[`BIT_ENABLE];
			if (wr_ctl)
				noise_filter_on <= wdata_i[`BIT_FILTER];
			if (wr_ictl) begin
				rx_full_irq_enable <= wdata_i[`BIT_RX_IRQ_EN];
				tx_empty_irq_enable <= wdata_i[`BIT_TX_IRQ_EN];
			end
			// Software writes to the data register.
			if (wr_dat) begin
				byte_data_field <= wdata_i[7:0];
				ack_bit <= wdata_i[`BIT_ACK];
				transmit_go <= wdata_i[`BIT_TX_GO];
				receive_go <= wdata_i[`BIT_RX_GO];
				tx_empty_pending <= 1'b0;
			end
			// Reading the data field drops the receive-ready flag.
			if (rd_dat)
				receive_ready_flag <= 1'b0;
			// Byte moves into the shifter: go bit clears unless software sets it again now.
			if (load_tx) begin
				transmit_go <= wr_dat && wdata_i[`BIT_TX_GO];
				tx_empty_pending <= 1'b1;
			end
			if (load_rx)
				receive_go <= wr_dat && wdata_i[`BIT_RX_GO];
			// Received byte lands in the data field.
			if (rx_done) begin
				byte_data_field <= shifter;
				receive_ready_flag <= 1'b1;
			end
			// Sampled acknowledge of a sent byte.
			if (tick && state == ST_TX && phase == 2'h2 && bit_cnt == `LAST_BIT)
				ack_bit <= sda_clean;
		end
	end

	// -------------------------------------------------------------
	// Bus engine
	// -------------------------------------------------------------
	// Each bit takes four ticks; the clock line is high in phases 2 and 3.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			phase <= `PHASE_ZERO;
			bit_cnt <= `BIT_CNT_ZERO;
			shifter <= `ZERO8;
			start_request <= 1'b0;
			stop_request <= 1'b0;
			bus_busy <= 1'b0;
			transmit_busy_flag <= 1'b0;
			receive_busy_flag <= 1'b0;
			scl_drive_low <= 1'b0;
			sda_drive_low <= 1'b0;
			tick_prev <= 1'b0;
		end else begin
			tick_prev <= bit_clk_i;
			if (wr_ctl) begin
				start_request <= wdata_i[`BIT_START];
				stop_request <= wdata_i[`BIT_STOP];
			end
			if (!module_enable_bit) begin
				// Disabled: release both lines and idle.
				state <= ST_IDLE;
				phase <= `PHASE_ZERO;
				bus_busy <= 1'b0;
				transmit_busy_flag <= 1'b0;
				receive_busy_flag <= 1'b0;
				scl_drive_low <= 1'b0;
				sda_drive_low <= 1'b0;
			end else if (tick) begin
				phase <= phase + 2'h1;
				case (state)
				ST_IDLE: begin
					phase <= `PHASE_ZERO;
					if (start_request && !bus_busy) begin
						state <= ST_START;
						phase <= 2'h1;
					end
				end
				ST_START: begin
					// Data falls while the clock is high, then clock goes low.
					if (phase == 2'h2)
						sda_drive_low <= 1'b1;
					if (phase == `PHASE_LAST) begin
						scl_drive_low <= 1'b1;
						start_request <= 1'b0;
						bus_busy <= 1'b1;
						state <= ST_HOLD;
					end
				end
				ST_RSTART: begin
					// Release data, raise clock, then drop data for a repeated start.
					if (phase == `PHASE_ZERO)
						sda_drive_low <= 1'b0;
					if (phase == 2'h1)
						scl_drive_low <= 1'b0;
					if (phase == 2'h2)
						sda_drive_low <= 1'b1;
					if (phase == `PHASE_LAST) begin
						scl_drive_low <= 1'b1;
						start_request <= 1'b0;
						state <= ST_HOLD;
					end
				end
				ST_STOP: begin
					// Data low, clock high, then data released high.
					if (phase == `PHASE_ZERO)
						sda_drive_low <= 1'b1;
					if (phase == 2'h1)
						scl_drive_low <= 1'b0;
					if (phase == 2'h2)
						sda_drive_low <= 1'b0;
					if (phase == `PHASE_LAST) begin
						stop_request <= 1'b0;
						bus_busy <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: begin
					// ST_HOLD, ST_TX and ST_RX: clock pulses and byte hand-over.
					if (state != ST_HOLD) begin
						if (phase == `PHASE_ZERO) begin
							if (bit_cnt == `LAST_BIT)
								sda_drive_low <= (state == ST_RX) && !ack_bit;
							else if (state == ST_TX)
								sda_drive_low <= !shifter[7];
							else
								sda_drive_low <= 1'b0;
						end
						if (phase == 2'h1)
							scl_drive_low <= 1'b0;
						if (phase == 2'h2 && state == ST_RX && bit_cnt != `LAST_BIT)
							shifter <= {shifter[6:0], sda_clean};
						if (phase == 2'h2 && state == ST_TX)
							shifter <= {shifter[6:0], 1'b0};
						if (phase == `PHASE_LAST) begin
							scl_drive_low <= 1'b1;
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
					if (phase == `PHASE_LAST &&
						(state == ST_HOLD || bit_cnt == `LAST_BIT)) begin
						bit_cnt <= `BIT_CNT_ZERO;
						transmit_busy_flag <= load_tx;
						receive_busy_flag <= load_rx;
						if (load_tx) begin
							shifter <= byte_data_field;
							state <= ST_TX;
						end else if (load_rx) begin
							state <= ST_RX;
						end else if (start_request) begin
							state <= ST_RSTART;
						end else if (stop_ok) begin
							state <= ST_STOP;
						end else begin
							state <= ST_HOLD;
							sda_drive_low <= 1'b0;
						end
					end
				end
				endcase
			end
		end
	end
endmodule // i2c_master_ctrl

// File: logic/i2c_master_defines.vh
// Register offsets, field positions, reset values and timing constants of the bus master unit.
`ifndef I2C_MASTER_DEFINES_VH
`define I2C_MASTER_DEFINES_VH
`define ADDR_MASTER_ENABLE 16'h4340
`define ADDR_MASTER_CONTROL 16'h4342
`define ADDR_MASTER_DATA 16'h4344
`define ADDR_IRQ_CONTROL 16'h4346
`define BIT_ENABLE 0
`define BIT_START 0
`define BIT_STOP 1
`define BIT_FILTER 4
`define BIT_TX_BUSY 8
`define BIT_RX_BUSY 9
`define BIT_ACK 8
`define BIT_TX_GO 9
`define BIT_RX_GO 10
`define BIT_RX_READY 11
`define BIT_TX_IRQ_EN 0
`define BIT_RX_IRQ_EN 1
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define LAST_BIT 4'h8
`define BIT_CNT_ZERO 4'h0
`define PHASE_ZERO 2'h0
`define PHASE_SAMPLE 2'h2
`define PHASE_LAST 2'h3
`define FILTER_LEN 3
`define FILTER_ONES 3'h7
`define FILTER_ZEROS 3'h0
`endif

// File: logic/line_filter.v
// Noise filter that passes a line level only after it has held for three samples.
`timescale 1ns/1ps
`include "i2c_master_defines.vh"
module line_filter (
	input wire clk_i,
	input wire rst_i,
	input wire on_i,
	input wire raw_i,
	output reg clean_o
);
	reg [`FILTER_LEN-1:0] hist;
	// -------------------------------------------------------------
	// Shift history and update the filtered level.
	// -------------------------------------------------------------
	// A bypassed filter follows the input directly; an enabled one needs agreement.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hist <= `FILTER_ONES;
			clean_o <= 1'b1;
		end else begin
			hist <= {hist[`FILTER_LEN-2:0], raw_i};
			if (!on_i)
				clean_o <= raw_i;
			else if (hist == `FILTER_ONES)
				clean_o <= 1'b1;
			else if (hist == `FILTER_ZEROS)
				clean_o <= 1'b0;
		end
	end
endmodule // line_filter

// File: tb/bus_slave_model.sv
// Behavioural two-wire slave that acknowledges, returns a byte and records what it was sent.
`timescale 1ns/1ps
module bus_slave_model (
	input wire scl_i,
	input wire sda_i,
	input wire ack_en_i,
	input wire rd_mode_i,
	input wire [7:0] tx_byte_i,
	output reg sda_oe_o,
	output reg [7:0] got_o,
	output reg [3:0] stops_o
);
	reg [3:0] cnt = 4'h0;
	initial sda_oe_o = 1'b0;
	initial got_o = 8'h00;
	initial stops_o = 4'h0;
	// A rising data line while the clock is high is a stop condition; each one is counted.
	always @(posedge sda_i) begin
		if (scl_i) begin
			stops_o <= stops_o + 4'h1;
		end
	end
	// A falling data line while the clock is high is a start; the bit count restarts.
	always @(negedge sda_i) begin
		if (scl_i) begin
			cnt <= 4'h0;
		end
	end
	// Bits are taken on the rising clock edge, most significant first; the ninth is skipped.
	always @(posedge scl_i) begin
		if (cnt < 4'h8) begin
			got_o <= {got_o[6:0], sda_i};
		end
		cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	end
	// The data line only changes while the clock is low, so it also follows late mode changes.
	always @(scl_i or cnt or rd_mode_i or ack_en_i or tx_byte_i) begin
		if (!scl_i) begin
			if (cnt == 4'h8) begin
				sda_oe_o = ack_en_i & ~rd_mode_i;
			end else begin
				sda_oe_o = rd_mode_i & ~tx_byte_i[3'h7 - cnt[2:0]];
			end
		end
	end
endmodule // bus_slave_model

// File: tb/i2c_master_ctrl_chk.sv
// Assertions on the register port and bus lines of the bus master unit.
`timescale 1ns/1ps
`include "i2c_master_defines.vh"
module i2c_master_ctrl_chk (
	input wire clk_i,
	input wire rst_i,
	input wire [15:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [15:0] rdata_o,
	input wire bit_clk_i,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_o,
	input wire scl_i,
	input wire scl_o,
	input wire scl_oe_o,
	input wire irq_o
);
	reg [1:0] ien;
	reg en;
	wire mapped = (addr_i[15:3] == 13'h0868) && !addr_i[0];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow copies of the enable bits, updated as the port writes them.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ien <= 2'h0;
			en <= 1'b0;
		end else if (wr_i && addr_i == `ADDR_IRQ_CONTROL) begin
			ien <= wdata_i[1:0];
		end else if (wr_i && addr_i == `ADDR_MASTER_ENABLE) begin
			en <= wdata_i[0];
		end
	end
	a_unmapped_zero:
		assert property (rd_i && !mapped |=> rdata_o == 16'h0000) else $error("unmapped read");
	a_enable_value:
		assert property (rd_i && addr_i == `ADDR_MASTER_ENABLE |=> rdata_o == {15'h0000, en})
		else $error("enable register value");
	a_ctl_reserved:
		assert property (rd_i && addr_i == `ADDR_MASTER_CONTROL |=> (rdata_o & 16'hfcec) == 0)
		else $error("control reserved bits");
	a_dat_reserved:
		assert property (rd_i && addr_i == `ADDR_MASTER_DATA |=> rdata_o[15:12] == 4'h0)
		else $error("data reserved bits");
	a_ictl_value:
		assert property (rd_i && addr_i == `ADDR_IRQ_CONTROL |=> rdata_o == {14'h0000, ien})
		else $error("interrupt control value");
	a_irq_masked:
		assert property (ien == 2'h0 |-> !irq_o) else $error("interrupt while masked");
	a_tx_cause_clear:
		assert property (wr_i && addr_i == `ADDR_MASTER_DATA && !wdata_i[9] && ien == 2'h1
			|=> !irq_o) else $error("transmit cause not cleared");
	a_lines_released:
		assert property (!en && !$past(en) |-> !sda_oe_o && !scl_oe_o) else $error("lines held");
	a_open_drain:
		assert property (!sda_o && !scl_o) else $error("line driven high");
	c_irq: cover property ($rose(irq_o));
	c_start: cover property ($rose(sda_oe_o) && !scl_oe_o);
	c_read_data: cover property (rd_i && addr_i == `ADDR_MASTER_DATA);
endmodule // i2c_master_ctrl_chk
bind i2c_master_ctrl i2c_master_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bit_clk_i(bit_clk_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe_o(scl_oe_o), .irq_o(irq_o));

// File: tb/i2c_master_ctrl_irq_test.sv
// Self-checking testbench of the bus master unit with a slave model on the two-wire bus.
`timescale 1ns/1ps
`include "i2c_master_defines.vh"
module i2c_master_ctrl_irq_test;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg [15:0] addr_i = 16'h0000;
	reg [15:0] wdata_i = 16'h0000;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg bit_clk_i = 1'b0;
	reg [2:0] bdiv = 3'h0;
	reg [3:0] n_stop = 4'h0;
	reg ack_en = 1'b1;
	reg rd_mode = 1'b0;
	reg [7:0] tx_byte = 8'hc3;
	reg [15:0] v;
	integer comparisons = 0;
	integer n_mismatch = 0;
	integer cycles = 0;
	wire [15:0] rdata_o;
	wire [7:0] got;
	wire [3:0] stops;
	wire sda_oe, scl_oe, s_oe, irq;
	// Both lines have pull-ups: the wire is low only while some party pulls it.
	wire sda = ~(sda_oe | s_oe);
	wire scl = ~scl_oe;
	i2c_master_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bit_clk_i(bit_clk_i), .sda_i(sda),
		.sda_o(), .sda_oe_o(sda_oe), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .irq_o(irq));
	bus_slave_model slv (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en), .rd_mode_i(rd_mode),
		.tx_byte_i(tx_byte), .sda_oe_o(s_oe), .got_o(got), .stops_o(stops));
	always #12.5 clk_i = ~clk_i;
	// Bit-rate ticks every eight clocks, slow enough for the noise filter.
	// A cycle ceiling cuts a hang short.
	always @(posedge clk_i) begin
		bdiv <= bdiv + 3'h1;
		bit_clk_i <= bdiv[2];
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop;
		end
	end
	task chk(input [15:0] got_v, input [15:0] exp_v);
		comparisons = comparisons + 1;
		if (got_v !== exp_v) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got_v, exp_v);
		end
	endtask
	task wr(input [15:0] a, input [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task rd(input [15:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask
	task rdc(input [15:0] a, input [15:0] m, input [15:0] e);
		rd(a);
		chk(v & m, e);
	endtask
	task poll(input [15:0] a, input [15:0] m, input [15:0] e);
		integer i;
		v = ~e;
		for (i = 0; i < 400 && (v & m) !== e; i = i + 1) rd(a);
		chk(v & m, e);
	endtask
	task wait_irq;
		integer i;
		for (i = 0; i < 800 && irq !== 1'b1; i = i + 1) @(posedge clk_i);
		#1;
		chk({15'h0000, irq}, 16'h0001);
	endtask
	task t_regs;
		rdc(`ADDR_MASTER_ENABLE, 16'hffff, 16'h0000);
		rdc(`ADDR_MASTER_CONTROL, 16'hffff, 16'h0000);
		rdc(`ADDR_MASTER_DATA, 16'hffff, 16'h0000);
		rdc(`ADDR_IRQ_CONTROL, 16'hffff, 16'h0000);
		wr(16'h4348, 16'h0001);
		rdc(16'h4348, 16'hffff, 16'h0000);
		wr(`ADDR_IRQ_CONTROL, 16'h0003);
		rdc(`ADDR_IRQ_CONTROL, 16'hffff, 16'h0003);
		wr(`ADDR_MASTER_CONTROL, 16'h0010);
		rdc(`ADDR_MASTER_CONTROL, 16'hffff, 16'h0010);
		wr(`ADDR_MASTER_CONTROL, 16'h0000);
		$display("registers test done");
	endtask
	task t_write;
		wr(`ADDR_MASTER_ENABLE, 16'h0001);
		wr(`ADDR_IRQ_CONTROL, 16'h0001);
		wr(`ADDR_MASTER_CONTROL, 16'h0011);
		poll(`ADDR_MASTER_CONTROL, 16'h0001, 16'h0000);
		wr(`ADDR_MASTER_DATA, 16'h02a5);
		wait_irq;
		rdc(`ADDR_MASTER_DATA, 16'h0200, 16'h0000);
		rdc(`ADDR_MASTER_CONTROL, 16'h0110, 16'h0110);
		wr(`ADDR_MASTER_DATA, 16'h005a);
		chk({15'h0000, irq}, 16'h0000);
		poll(`ADDR_MASTER_CONTROL, 16'h0100, 16'h0000);
		chk({8'h00, got}, 16'h00a5);
		rdc(`ADDR_MASTER_DATA, 16'h01ff, 16'h005a);
		$display("write test done");
	endtask
	task t_nak;
		ack_en = 1'b0;
		wr(`ADDR_IRQ_CONTROL, 16'h0000);
		wr(`ADDR_MASTER_CONTROL, 16'h0001);
		poll(`ADDR_MASTER_CONTROL, 16'h0001, 16'h0000);
		wr(`ADDR_MASTER_DATA, 16'h0281);
		poll(`ADDR_MASTER_DATA, 16'h0200, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		poll(`ADDR_MASTER_CONTROL, 16'h0100, 16'h0000);
		rdc(`ADDR_MASTER_DATA, 16'h0100, 16'h0100);
		chk({8'h00, got}, 16'h0081);
		$display("repeated start test done");
	endtask
	task t_read;
		rd_mode = 1'b1;
		wr(`ADDR_IRQ_CONTROL, 16'h0002);
		wr(`ADDR_MASTER_DATA, 16'h0500);
		poll(`ADDR_MASTER_CONTROL, 16'h0200, 16'h0200);
		wait_irq;
		rdc(`ADDR_MASTER_DATA, 16'hffff, 16'h09c3);
		chk({15'h0000, irq}, 16'h0000);
		rdc(`ADDR_MASTER_DATA, 16'h0800, 16'h0000);
		poll(`ADDR_MASTER_CONTROL, 16'h0200, 16'h0000);
		rd_mode = 1'b0;
		$display("read test done");
	endtask
	task t_stop;
		n_stop = stops;
		wr(`ADDR_MASTER_CONTROL, 16'h0002);
		poll(`ADDR_MASTER_CONTROL, 16'h0002, 16'h0000);
		chk({14'h0000, sda_oe, scl_oe}, 16'h0000);
		chk({12'h000, stops - n_stop}, 16'h0001);
		wr(`ADDR_MASTER_ENABLE, 16'h0000);
		rdc(`ADDR_MASTER_ENABLE, 16'hffff, 16'h0000);
		$display("stop test done");
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Main sequence: reset for ten cycles, then each scenario in turn.
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_write;
		t_nak;
		t_read;
		t_stop;
		report_and_stop;
	end
endmodule // i2c_master_ctrl_irq_test
